// File: dual_dac_serial_load_logic.sv
/*
 * Load logic of a dual 12-bit converter: the serial word arrives on the link
 * clock, the load strobes and preset pins are synchronised into the core
 * clock, where the two holding registers live.
 * Assumes the host holds both strobes high while shifting, so the word is
 * static when a strobe falls and can cross as a level.
 * Assumes the preset pin stays low for at least two core cycles, because it
 * is sampled through a synchroniser rather than acting on the flops at once.
 * Assumes strobes stay low and high for at least two core cycles each.
 */
module dual_dac_serial_load_logic #(
    parameter int WORD_W = dac_load_pkg::WORD_W,
    parameter int DATA_W = dac_load_pkg::DATA_W
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic serial_clk_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in_pin_in,
    input wire logic load_strobe_a_n_in,
    input wire logic load_strobe_b_n_in,
    input wire logic async_preset_n_in,
    input wire logic preset_level_in,
    output logic serial_chain_out,
    output logic [DATA_W-1:0] channel_a_hold_reg_out,
    output logic [DATA_W-1:0] channel_b_hold_reg_out
);
    // Decides whether one channel loads: own strobe in hardware mode,
    // any strobe gated by the channel's select bit in decode mode.
    function automatic logic channel_load(input logic mode, input logic own_fall,
                                          input logic any_fall, input logic dsel);
        channel_load = mode ? (any_fall & dsel) : own_fall;
    endfunction : channel_load

    logic [WORD_W-1:0] link_word;
    logic [WORD_W-1:0] word_meta;
    logic [WORD_W-1:0] word_sync;
    logic [2:0] strobe_a_pipe;
    logic [2:0] strobe_b_pipe;
    logic [1:0] preset_n_pipe;
    logic [1:0] level_pipe;
    logic [DATA_W-1:0] channel_a_hold_reg;
    logic [DATA_W-1:0] channel_b_hold_reg;

    // Link-side shift register; its top stage drives the chain output.
    input_shift_reg #(
        .WORD_W(WORD_W)
    ) u_shift (
        .serial_clk_in(serial_clk_in),
        .rst_in(rst_in),
        .chip_select_n_in(chip_select_n_in),
        .serial_in_pin_in(serial_in_pin_in),
        .word_out(link_word),
        .serial_chain_out(serial_chain_out)
    );

    // Two-stage synchronisers. The word is static while a strobe is low,
    // so a level crossing is enough; the strobes get a third stage that
    // only the edge detector reads.
    // A word still moving when a strobe falls could be caught half old and
    // half new, which is why the host must stop shifting a few core cycles
    // before it strobes.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_meta <= dac_load_pkg::SHIFT_RESET;
            word_sync <= dac_load_pkg::SHIFT_RESET;
            strobe_a_pipe <= 3'h7;
            strobe_b_pipe <= 3'h7;
            preset_n_pipe <= 2'h3;
            level_pipe <= 2'h0;
        end else begin
            word_meta <= link_word;
            word_sync <= word_meta;
            strobe_a_pipe <= {strobe_a_pipe[1:0], load_strobe_a_n_in};
            strobe_b_pipe <= {strobe_b_pipe[1:0], load_strobe_b_n_in};
            preset_n_pipe <= {preset_n_pipe[0], async_preset_n_in};
            level_pipe <= {level_pipe[0], preset_level_in};
        end
    end

    // Edge detection and decode; chip select plays no part here.
    wire fall_a = strobe_a_pipe[2] & ~strobe_a_pipe[1];
    wire fall_b = strobe_b_pipe[2] & ~strobe_b_pipe[1];
    wire any_fall = fall_a | fall_b;
    wire word_mode = word_sync[dac_load_pkg::MODE_BIT];
    wire dsel_a = word_sync[dac_load_pkg::DSEL_A_BIT];
    wire dsel_b = word_sync[dac_load_pkg::DSEL_B_BIT];
    wire [DATA_W-1:0] word_data = word_sync[dac_load_pkg::DATA_MSB:0];
    wire preset_active = ~preset_n_pipe[1];
    wire [DATA_W-1:0] preset_value = level_pipe[1] ? dac_load_pkg::PRESET_HALF
                                                   : dac_load_pkg::PRESET_ZERO;
    wire load_a = channel_load(word_mode, fall_a, any_fall, dsel_a);
    wire load_b = channel_load(word_mode, fall_b, any_fall, dsel_b);

    // Holding registers: preset wins over a load, otherwise they hold.
    // The preset is applied on every core edge while it stays active, so a
    // strobe that falls during a preset is lost rather than queued.
    // The reset branch loads constants only; the preset level never reaches
    // an asynchronous path.
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            channel_a_hold_reg <= dac_load_pkg::PRESET_ZERO;
            channel_b_hold_reg <= dac_load_pkg::PRESET_ZERO;
        end else if (preset_active) begin
            channel_a_hold_reg <= preset_value;
            channel_b_hold_reg <= preset_value;
        end else begin
            if (load_a) begin
                channel_a_hold_reg <= word_data;
            end
            if (load_b) begin
                channel_b_hold_reg <= word_data;
            end
        end
    end

    // Channels drive the converter inputs continuously.
    assign channel_a_hold_reg_out = channel_a_hold_reg;
    assign channel_b_hold_reg_out = channel_b_hold_reg;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    a_hw_load_a: assert property (
        !preset_active && !word_mode && fall_a |=> channel_a_hold_reg == $past(word_data))
        else $error("Hardware strobe A did not load channel A.");
    a_hw_load_b: assert property (
        !preset_active && !word_mode && fall_b && !fall_a
        |=> channel_b_hold_reg == $past(word_data) && $stable(channel_a_hold_reg))
        else $error("Hardware strobe B loaded the wrong channel.");
    a_sw_load_a: assert property (
        !preset_active && word_mode && dsel_a && !dsel_b && any_fall
        |=> channel_a_hold_reg == $past(word_data) && $stable(channel_b_hold_reg))
        else $error("Decode A did not load channel A only.");
    a_sw_no_load: assert property (
        !preset_active && word_mode && !dsel_a && !dsel_b
        |=> $stable(channel_a_hold_reg) && $stable(channel_b_hold_reg))
        else $error("Decode with no select changed a channel.");
    a_preset_half: assert property (
        preset_active && level_pipe[1] |=> channel_a_hold_reg == 12'h800
                                            && channel_b_hold_reg == 12'h800)
        else $error("Preset high level did not give half scale.");
    a_preset_zero: assert property (
        preset_active && !level_pipe[1] |=> channel_a_hold_reg == 12'h000
                                             && channel_b_hold_reg == 12'h000)
        else $error("Preset low level did not give zero.");
    a_hold_value: assert property (
        !preset_active && !load_a |=> $stable(channel_a_hold_reg))
        else $error("Channel A changed without a load.");
    a_pin_to_load: assert property (
        $fell(load_strobe_a_n_in) ##1 (load_strobe_a_n_in == 1'b0) [* 2]
        |-> ##[0:2] fall_a)
        else $error("Strobe A fall not detected in time.");
    a_pin_to_load_b: assert property (
        $fell(load_strobe_b_n_in) ##1 (load_strobe_b_n_in == 1'b0) [* 2]
        |-> ##[0:2] fall_b)
        else $error("Strobe B fall not detected in time.");

    // Further hardware mode checks: both strobes, and no strobe at all.
    a_hw_load_both: assert property (
        !preset_active && !word_mode && fall_a && fall_b
        |=> channel_a_hold_reg == $past(word_data) && channel_b_hold_reg == $past(word_data))
        else $error("Both strobes did not load both channels.");
    a_hw_no_strobe: assert property (
        !preset_active && !word_mode && !fall_a && !fall_b
        |=> $stable(channel_a_hold_reg) && $stable(channel_b_hold_reg))
        else $error("A channel changed with no strobe in hardware mode.");

    // Further decode mode checks: channel B alone, both, and a strobe
    // whose own channel is not selected.
    a_sw_load_b: assert property (
        !preset_active && word_mode && dsel_b && !dsel_a && any_fall
        |=> channel_b_hold_reg == $past(word_data) && $stable(channel_a_hold_reg))
        else $error("Decode B did not load channel B only.");
    a_sw_load_both: assert property (
        !preset_active && word_mode && dsel_a && dsel_b && any_fall
        |=> channel_a_hold_reg == $past(word_data) && channel_b_hold_reg == $past(word_data))
        else $error("Decode of both did not load both channels.");
    a_sw_own_ignored: assert property (
        !preset_active && word_mode && fall_a && !dsel_a
        |=> $stable(channel_a_hold_reg))
        else $error("Strobe A loaded channel A without its select bit.");

    // Holding and preset behaviour.
    a_hold_value_b: assert property (
        !preset_active && !load_b
        |=> $stable(channel_b_hold_reg))
        else $error("Channel B changed without a load.");
    a_preset_priority: assert property (
        preset_active && any_fall
        |=> channel_a_hold_reg == $past(preset_value) && channel_b_hold_reg == $past(preset_value))
        else $error("A load overrode an active preset.");
    a_preset_sync: assert property (
        $fell(async_preset_n_in) ##1 !async_preset_n_in
        |-> ##1 preset_active)
        else $error("Preset pin not seen in time.");

    // Main scenarios to be reached.
    c_hw_both: cover property (!word_mode && fall_a && fall_b);
    c_sw_only_b: cover property (word_mode && dsel_b && !dsel_a && any_fall);
    c_sw_both: cover property (word_mode && dsel_a && dsel_b && any_fall);
    c_preset_half: cover property (preset_active && level_pipe[1]);
endmodule : dual_dac_serial_load_logic

// File: dac_load_pkg.sv
/*
 * Shared constants of the dual-channel converter load logic: word layout,
 * preset values and synchroniser depth.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package dac_load_pkg;
    // Serial word layout, first bit shifted in ends up in the top position.
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam int MODE_BIT = 15;
    localparam int DSEL_B_BIT = 14;
    localparam int DSEL_A_BIT = 13;
    localparam int SPARE_BIT = 12;
    localparam int DATA_MSB = 11;

    // Values forced into both holding registers by the preset pin.
    localparam logic [11:0] PRESET_HALF = 12'h800;
    localparam logic [11:0] PRESET_ZERO = 12'h000;

    // Reset value of the serial shift register.
    localparam logic [15:0] SHIFT_RESET = 16'h0000;

    // Number of flip-flops in each pin synchroniser.
    localparam int SYNC_STAGES = 2;
endpackage : dac_load_pkg

// File: input_shift_reg.sv
/*
 * Serial input shift register, clocked by the link's own serial clock.
 * Assumes the chip select comes from the same host logic that makes the
 * serial clock, so it is sampled on that clock with no synchroniser.
 */
module input_shift_reg #(
    parameter int WORD_W = dac_load_pkg::WORD_W
) (
    input wire logic serial_clk_in,
    input wire logic rst_in,
    input wire logic chip_select_n_in,
    input wire logic serial_in_pin_in,
    output logic [WORD_W-1:0] word_out,
    output logic serial_chain_out
);
    logic [WORD_W-1:0] shift_word;
    logic [WORD_W-1:0] next_shift_word;

    // Shift one place when selected, otherwise keep the contents.
    assign next_shift_word = chip_select_n_in ? shift_word
                             : {shift_word[WORD_W-2:0], serial_in_pin_in};

    // The register itself; the top stage is the chain output.
    always_ff @(posedge serial_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_word <= dac_load_pkg::SHIFT_RESET;
        end else begin
            shift_word <= next_shift_word;
        end
    end

    assign word_out = shift_word;
    assign serial_chain_out = shift_word[WORD_W-1];

    // Checks of the shift behaviour on the link clock.
    a_shift_step: assert property (@(posedge serial_clk_in) disable iff (rst_in)
        !chip_select_n_in |=> shift_word == {$past(shift_word[WORD_W-2:0]), $past(serial_in_pin_in)})
        else $error("Shift register did not take the serial bit.");
    a_deselect_hold: assert property (@(posedge serial_clk_in) disable iff (rst_in)
        chip_select_n_in |=> $stable(shift_word))
        else $error("Shift register changed while deselected.");
    c_full_word: cover property (@(posedge serial_clk_in) disable iff (rst_in)
        !chip_select_n_in [* 8] ##1 !chip_select_n_in [* 8]);
endmodule : input_shift_reg

// File: host_model.sv
/*
 * Host side model: makes the serial clock, chip select and serial data.
 * Assumes the bench drives the load strobes and holds them high meanwhile.
 */
module host_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic sdi_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b1;
    end
    // Shifts a word first bit first; the clock runs for all 16 bits, and chip select goes low only when sel is set.
    task automatic send(input logic [15:0] word, input logic sel);
        cs_n_out = ~sel;
        for (int i = 15; i >= 0; i--) begin
            sdi_out = word[i];
            #7.5 sclk_out = 1'b1;
            #7.5 sclk_out = 1'b0;
        end
        #7.5 cs_n_out = 1'b1;
        sdi_out = ~sdi_out; // A released data line shows the inverse of its last bit.
    endtask : send
endmodule : host_model

// File: tb_top.sv
/*
 * Self-checking bench of the dual converter load logic.
 * Assumes a core clock of 100 MHz and a host model making the link clock.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic load_a_n = 1'b1;
    logic load_b_n = 1'b1;
    logic preset_n = 1'b1;
    logic preset_level = 1'b0;
    logic sclk, cs_n, serial_in_pin, chain_out;
    logic [11:0] ch_a, ch_b;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(serial_in_pin));
    dual_dac_serial_load_logic i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .serial_clk_in(sclk), .chip_select_n_in(cs_n), .serial_in_pin_in(serial_in_pin),
        .load_strobe_a_n_in(load_a_n), .load_strobe_b_n_in(load_b_n),
        .async_preset_n_in(preset_n), .preset_level_in(preset_level),
        .serial_chain_out(chain_out), .channel_a_hold_reg_out(ch_a),
        .channel_b_hold_reg_out(ch_b));
    // Core clock and the hang limit.
    always #5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : wait_cyc
    // Shifts a word, lets it settle, then pulses the chosen strobes.
    task automatic load(input logic [15:0] word, input logic a, input logic b);
        i_host.send(word, 1'b1);
        wait_cyc(4);
        load_a_n = ~a;
        load_b_n = ~b;
        wait_cyc(3);
        load_a_n = 1'b1;
        load_b_n = 1'b1;
        wait_cyc(5);
    endtask : load
    task automatic t_hw();
        check(ch_a, 16'h0000);
        load(16'h1abc, 1'b1, 1'b0);
        check(ch_a, 16'h0abc);
        check(ch_b, 16'h0000);
        load(16'h1123, 1'b0, 1'b1);
        check(ch_b, 16'h0123);
        check(ch_a, 16'h0abc);
        load(16'h0456, 1'b1, 1'b1);
        check(ch_a, 16'h0456);
        check(ch_b, 16'h0456);
    endtask : t_hw
    // Every decode code, alternating strobes while the other is held high.
    task automatic t_sw();
        logic [11:0] exp_a, exp_b, data;
        exp_a = 12'h456;
        exp_b = 12'h456;
        for (int code = 0; code < 4; code++) begin
            data = 12'h900 + 12'(code);
            load({1'b1, code[1], code[0], 1'b0, data}, ~code[0], code[0]);
            if (code[0]) exp_a = data;
            if (code[1]) exp_b = data;
            check(ch_a, 16'(exp_a));
            check(ch_b, 16'(exp_b));
            check(16'(chain_out), 16'h0001);
        end
    endtask : t_sw
    // Clocks with chip select high must leave the word alone.
    task automatic t_cs();
        load(16'h0321, 1'b1, 1'b0);
        i_host.send(16'hffff, 1'b0);
        wait_cyc(4);
        load_b_n = 1'b0;
        wait_cyc(3);
        load_b_n = 1'b1;
        wait_cyc(5);
        check(ch_b, 16'h0321);
        check(ch_a, 16'h0321);
    endtask : t_cs
    task automatic t_preset();
        for (int lvl = 1; lvl >= 0; lvl--) begin
            preset_level = lvl[0];
            preset_n = 1'b0;
            wait_cyc(4);
            check(ch_a, lvl[0] ? 16'h0800 : 16'h0000);
            check(ch_b, lvl[0] ? 16'h0800 : 16'h0000);
            preset_n = 1'b1;
            wait_cyc(4);
            check(ch_a, lvl[0] ? 16'h0800 : 16'h0000);
        end
    endtask : t_preset
    task automatic conclude();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Main sequence after eight cycles of reset.
    initial begin
        wait_cyc(8);
        rst_in = 1'b0;
        wait_cyc(2);
        t_hw();
        t_sw();
        t_cs();
        t_preset();
        conclude();
    end
endmodule : tb_top
